// ==== verilog/spi_port_fifo_frame.sv ====
`timescale 1ns/10ps
// How it works
// - Master or slave, chosen edge, idle level, select
// - Words are 8 bits, 16 when wide
// - Framing only while framed enable is set
// - Frame pulse polarity and first-bit coincidence configurable
// - Clock output off: pin released, external clock
// - Data output off: pin released, reception continues
// - Buffer queues transfers, single or multi, counts
// - Remember whether last entry was CPU or receiver
// - Event flag also raised on receive during overrun
// - Separate transmit full and receive non-empty status
// - Port idle while port enable is clear
// - Controller select makes master; sample phase picks
// - Master rate from primary and secondary prescale
// - Prescalers run from the instruction-rate clock
module spi_port_fifo_frame (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic port_enable,
	input wire logic controller_select,
	input wire logic wide_word_select,
	input wire logic framed_enable,
	input wire logic fsync_active_high,
	input wire logic fsync_with_first_bit,
	input wire logic clock_output_off,
	input wire logic data_output_off,
	input wire logic idle_polarity_select,
	input wire logic clock_edge_select,
	input wire logic sample_phase,
	input wire logic [1:0] primary_prescale,
	input wire logic [2:0] secondary_prescale,
	input wire logic select_input_enable,
	input wire logic buffer_multi,
	input wire logic overrun_clear,
	input wire logic event_clear,
	input wire logic tx_wr,
	input wire logic [spi_port_pkg::WORD_W-1:0] tx_data,
	input wire logic rx_rd,
	input wire logic sck_in,
	input wire logic sdi_in,
	input wire logic sel_b_in,
	input wire logic fsync_in,
	output logic [spi_port_pkg::WORD_W-1:0] rx_data,
	output logic tx_buffer_full,
	output logic rx_buffer_full,
	output logic receive_overrun,
	output logic transfer_event_flag,
	output logic [spi_port_pkg::CNT_W-1:0] pending_count,
	output logic last_from_cpu,
	output logic sck_out,
	output logic sck_oe,
	output logic sdo_out,
	output logic sdo_oe,
	output logic fsync_out,
	output logic fsync_oe
);
	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [spi_port_pkg::PIN_N-1:0] pin_s1_ff;
	logic [spi_port_pkg::PIN_N-1:0] pin_s2_ff;
	logic sck_prev_ff;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_s1_ff <= '0;
			pin_s2_ff <= '0;
		end else begin
			pin_s1_ff <= {fsync_in, sel_b_in, sdi_in, sck_in};
			pin_s2_ff <= pin_s1_ff;
		end
	end

	// ****************************************************************
	// Engine and buffer state
	// ****************************************************************
	spi_port_pkg::state_t state_ff, nxt_state;
	logic [spi_port_pkg::DIV_W-1:0] div_ff, nxt_div;
	logic phase_ff, nxt_phase;
	logic [3:0] bit_ff, nxt_bit;
	logic [spi_port_pkg::WORD_W-1:0] tx_sh_ff, nxt_tx_sh;
	logic [spi_port_pkg::WORD_W-1:0] rx_sh_ff, nxt_rx_sh;
	logic [spi_port_pkg::PTR_W-1:0] tx_rp_ff, nxt_tx_rp, tx_wp_ff, nxt_tx_wp;
	logic [spi_port_pkg::PTR_W-1:0] rx_rp_ff, nxt_rx_rp, rx_wp_ff, nxt_rx_wp;
	logic [spi_port_pkg::CNT_W-1:0] tx_cnt_ff, nxt_tx_cnt, rx_cnt_ff, nxt_rx_cnt;
	logic ovr_ff, nxt_ovr, evt_ff, nxt_evt, last_cpu_ff, nxt_last_cpu;
	logic tx_full_ff, nxt_tx_full, rx_full_ff, nxt_rx_full;
	logic [spi_port_pkg::CNT_W-1:0] pend_ff, nxt_pend;
	logic sck_o_ff, nxt_sck_o, sck_e_ff, nxt_sck_e;
	logic sdo_o_ff, nxt_sdo_o, sdo_e_ff, nxt_sdo_e;
	logic fs_o_ff, nxt_fs_o, fs_e_ff, nxt_fs_e;

	logic [spi_port_pkg::WORD_W-1:0] tx_head;
	logic tx_push, rx_push;
	logic [spi_port_pkg::WORD_W-1:0] rx_word;
	logic [spi_port_pkg::CNT_W-1:0] limit;
	logic int_clk, ext_lvl, lead_ev, trail_ev, tick, sample_ev, shift_ev;
	logic selected, frame_ok, tx_pop, sdi_bit;
	logic ovr_set, evt_set;
	logic [3:0] last_bit;

	word_store tx_store (
		.clk(clk),
		.rst_b(rst_b),
		.wr_en(tx_push),
		.wr_addr(tx_wp_ff),
		.wr_data(tx_data),
		.rd_addr(nxt_tx_rp),
		.rd_data(tx_head)
	);

	word_store rx_store (
		.clk(clk),
		.rst_b(rst_b),
		.wr_en(rx_push),
		.wr_addr(rx_wp_ff),
		.wr_data(rx_word),
		.rd_addr(nxt_rx_rp),
		.rd_data(rx_data)
	);

	always_comb begin
		nxt_state = state_ff;
		nxt_div = div_ff;
		nxt_phase = phase_ff;
		nxt_bit = bit_ff;
		nxt_tx_sh = tx_sh_ff;
		nxt_rx_sh = rx_sh_ff;
		nxt_tx_rp = tx_rp_ff;
		nxt_tx_wp = tx_wp_ff;
		nxt_rx_rp = rx_rp_ff;
		nxt_rx_wp = rx_wp_ff;
		nxt_ovr = ovr_ff;
		nxt_evt = evt_ff;
		nxt_last_cpu = last_cpu_ff;
		rx_push = 1'b0;
		rx_word = spi_port_pkg::WORD_ZERO;
		tx_pop = 1'b0;
		ovr_set = 1'b0;
		evt_set = 1'b0;
		sdi_bit = pin_s2_ff[spi_port_pkg::PIN_SDI];
		limit = buffer_multi ? spi_port_pkg::MULTI_LIMIT : spi_port_pkg::SINGLE_LIMIT;
		last_bit = wide_word_select ? spi_port_pkg::LAST_BIT_WIDE
			: spi_port_pkg::LAST_BIT_NARROW;
		// External clock timing when slave or when the clock pin is released
		int_clk = controller_select && !clock_output_off;
		ext_lvl = pin_s2_ff[spi_port_pkg::PIN_SCK] ^ idle_polarity_select;
		tick = int_clk && (state_ff != spi_port_pkg::st_idle) && (div_ff == '0);
		if (int_clk) begin
			lead_ev = tick && !phase_ff;
			trail_ev = tick && phase_ff;
		end else begin
			lead_ev = ext_lvl && !sck_prev_ff;
			trail_ev = !ext_lvl && sck_prev_ff;
		end
		// CKE high: sample on leading, shift on trailing; late sample moves to trailing in master mode only
		sample_ev = (clock_edge_select && !(controller_select && sample_phase))
			? lead_ev : trail_ev;
		shift_ev = clock_edge_select ? trail_ev : (lead_ev && (bit_ff != 4'h0));
		selected = !select_input_enable || !pin_s2_ff[spi_port_pkg::PIN_SEL_B];
		frame_ok = !framed_enable
			|| (pin_s2_ff[spi_port_pkg::PIN_FSYNC] == fsync_active_high);
		tx_push = tx_wr && (tx_cnt_ff < limit);
		if (int_clk && (state_ff != spi_port_pkg::st_idle)) begin
			if (div_ff == '0) begin
				nxt_div = spi_port_pkg::half_period(primary_prescale, secondary_prescale)
					- 10'h001;
				nxt_phase = !phase_ff;
			end else begin
				nxt_div = div_ff - 10'h001;
			end
		end
		unique case (state_ff)
			spi_port_pkg::st_idle: begin
				nxt_phase = 1'b0;
				nxt_div = spi_port_pkg::half_period(primary_prescale, secondary_prescale)
					- 10'h001;
				nxt_bit = 4'h0;
				if (port_enable && controller_select && (tx_cnt_ff != '0)) begin
					tx_pop = 1'b1;
					nxt_tx_sh = tx_head;
					nxt_state = (framed_enable && !fsync_with_first_bit)
						? spi_port_pkg::st_sync : spi_port_pkg::st_busy;
				end else if (port_enable && !controller_select && selected && frame_ok) begin
					tx_pop = tx_cnt_ff != '0;
					nxt_tx_sh = tx_pop ? tx_head : spi_port_pkg::WORD_ZERO;
					nxt_state = spi_port_pkg::st_busy;
				end
			end
			spi_port_pkg::st_sync: begin
				if (trail_ev) begin
					nxt_state = spi_port_pkg::st_busy;
				end
			end
			spi_port_pkg::st_busy: begin
				if (sample_ev) begin
					nxt_rx_sh = {rx_sh_ff[spi_port_pkg::WORD_W-2:0], sdi_bit};
				end
				if (shift_ev) begin
					nxt_tx_sh = {tx_sh_ff[spi_port_pkg::WORD_W-2:0], 1'b0};
				end
				if (trail_ev) begin
					nxt_bit = bit_ff + 4'h1;
					if (bit_ff == last_bit) begin
						rx_word = nxt_rx_sh;
						if (!wide_word_select) begin
							rx_word = {8'h00, nxt_rx_sh[spi_port_pkg::NARROW_W-1:0]};
						end
						rx_push = rx_cnt_ff < limit;
						ovr_set = !rx_push;
						if (!rx_push) begin
							nxt_ovr = 1'b1;
						end
						// Completion raises the flag, overrun or not
						evt_set = 1'b1;
						nxt_evt = 1'b1;
						nxt_state = spi_port_pkg::st_idle;
					end
				end
				if (!controller_select && select_input_enable
					&& pin_s2_ff[spi_port_pkg::PIN_SEL_B]) begin
					nxt_state = spi_port_pkg::st_idle;
				end
			end
		endcase
		if (!port_enable) begin
			nxt_state = spi_port_pkg::st_idle;
		end
		// A new overrun or completion in the clearing cycle wins over the clear
		if (overrun_clear && !ovr_set) begin
			nxt_ovr = 1'b0;
		end
		if (event_clear && !evt_set) begin
			nxt_evt = 1'b0;
		end
		if (tx_push) begin
			nxt_tx_wp = tx_wp_ff + 2'h1;
			nxt_last_cpu = 1'b1;
		end
		if (tx_pop) begin
			nxt_tx_rp = tx_rp_ff + 2'h1;
		end
		if (rx_push) begin
			nxt_rx_wp = rx_wp_ff + 2'h1;
			nxt_last_cpu = 1'b0;
		end
		if (rx_rd && (rx_cnt_ff != '0)) begin
			nxt_rx_rp = rx_rp_ff + 2'h1;
		end
		nxt_tx_cnt = tx_cnt_ff + CNT_W_ONE(tx_push) - CNT_W_ONE(tx_pop);
		nxt_rx_cnt = rx_cnt_ff + CNT_W_ONE(rx_push) - CNT_W_ONE(rx_rd && (rx_cnt_ff != '0));
		nxt_tx_full = nxt_tx_cnt >= limit;
		nxt_rx_full = nxt_rx_cnt != '0;
		nxt_pend = nxt_tx_cnt;
		nxt_sck_o = (int_clk ? nxt_phase : 1'b0) ^ idle_polarity_select;
		nxt_sck_e = port_enable && int_clk;
		nxt_sdo_o = wide_word_select ? nxt_tx_sh[15] : nxt_tx_sh[7];
		nxt_sdo_e = port_enable && !data_output_off && (controller_select || selected);
		nxt_fs_o = fsync_active_high ^ !((nxt_state == spi_port_pkg::st_sync)
			|| ((nxt_state == spi_port_pkg::st_busy) && fsync_with_first_bit
			&& (nxt_bit == 4'h0)));
		nxt_fs_e = port_enable && framed_enable && controller_select;
	end

	function automatic logic [spi_port_pkg::CNT_W-1:0] CNT_W_ONE(input logic b);
		return {{(spi_port_pkg::CNT_W-1){1'b0}}, b};
	endfunction : CNT_W_ONE

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= spi_port_pkg::st_idle;
			div_ff <= '0;
			phase_ff <= 1'b0;
			bit_ff <= 4'h0;
			tx_sh_ff <= spi_port_pkg::WORD_ZERO;
			rx_sh_ff <= spi_port_pkg::WORD_ZERO;
			tx_rp_ff <= '0;
			tx_wp_ff <= '0;
			rx_rp_ff <= '0;
			rx_wp_ff <= '0;
			tx_cnt_ff <= '0;
			rx_cnt_ff <= '0;
			ovr_ff <= 1'b0;
			evt_ff <= 1'b0;
			last_cpu_ff <= 1'b0;
			tx_full_ff <= 1'b0;
			rx_full_ff <= 1'b0;
			pend_ff <= '0;
			sck_o_ff <= 1'b0;
			sck_e_ff <= 1'b0;
			sdo_o_ff <= 1'b0;
			sdo_e_ff <= 1'b0;
			fs_o_ff <= 1'b0;
			fs_e_ff <= 1'b0;
			sck_prev_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			div_ff <= nxt_div;
			phase_ff <= nxt_phase;
			bit_ff <= nxt_bit;
			tx_sh_ff <= nxt_tx_sh;
			rx_sh_ff <= nxt_rx_sh;
			tx_rp_ff <= nxt_tx_rp;
			tx_wp_ff <= nxt_tx_wp;
			rx_rp_ff <= nxt_rx_rp;
			rx_wp_ff <= nxt_rx_wp;
			tx_cnt_ff <= nxt_tx_cnt;
			rx_cnt_ff <= nxt_rx_cnt;
			ovr_ff <= nxt_ovr;
			evt_ff <= nxt_evt;
			last_cpu_ff <= nxt_last_cpu;
			tx_full_ff <= nxt_tx_full;
			rx_full_ff <= nxt_rx_full;
			pend_ff <= nxt_pend;
			sck_o_ff <= nxt_sck_o;
			sck_e_ff <= nxt_sck_e;
			sdo_o_ff <= nxt_sdo_o;
			sdo_e_ff <= nxt_sdo_e;
			fs_o_ff <= nxt_fs_o;
			fs_e_ff <= nxt_fs_e;
			sck_prev_ff <= ext_lvl;
		end
	end

	assign tx_buffer_full = tx_full_ff;
	assign rx_buffer_full = rx_full_ff;
	assign receive_overrun = ovr_ff;
	assign transfer_event_flag = evt_ff;
	assign pending_count = pend_ff;
	assign last_from_cpu = last_cpu_ff;
	assign sck_out = sck_o_ff;
	assign sck_oe = sck_e_ff;
	assign sdo_out = sdo_o_ff;
	assign sdo_oe = sdo_e_ff;
	assign fsync_out = fs_o_ff;
	assign fsync_oe = fs_e_ff;
endmodule : spi_port_fifo_frame

// ==== verilog/spi_port_pkg.sv ====
package spi_port_pkg;

	// ****************************************************************
	// Word and buffer shape
	// ****************************************************************
	localparam int WORD_W = 16;
	localparam int NARROW_W = 8;
	localparam int DEPTH = 4;
	localparam int PTR_W = 2;
	localparam int CNT_W = 3;
	localparam int DIV_W = 10;
	localparam logic [CNT_W-1:0] MULTI_LIMIT = 3'h4;
	localparam logic [CNT_W-1:0] SINGLE_LIMIT = 3'h1;
	localparam logic [3:0] LAST_BIT_WIDE = 4'hf;
	localparam logic [3:0] LAST_BIT_NARROW = 4'h7;
	localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;

	// ****************************************************************
	// Pin synchroniser lanes
	// ****************************************************************
	localparam int PIN_N = 4;
	localparam int PIN_SCK = 0;
	localparam int PIN_SDI = 1;
	localparam int PIN_SEL_B = 2;
	localparam int PIN_FSYNC = 3;

	// ****************************************************************
	// Prescale ratios, in clk cycles per half period of the serial clock
	// ****************************************************************
	function automatic logic [DIV_W-1:0] half_period(input logic [1:0] pri, input logic [2:0] sec);
		logic [DIV_W-1:0] p;
		logic [DIV_W-1:0] s;
		p = 10'h001 << (6'(2'h3 - pri) * 6'h2);
		s = 10'h008 - DIV_W'(sec);
		return DIV_W'(p * s);
	endfunction : half_period

	typedef enum logic [1:0] {st_idle, st_sync, st_busy} state_t;

endpackage : spi_port_pkg

// ==== verilog/word_store.sv ====
`timescale 1ns/10ps
module word_store (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic wr_en,
	input wire logic [spi_port_pkg::PTR_W-1:0] wr_addr,
	input wire logic [spi_port_pkg::WORD_W-1:0] wr_data,
	input wire logic [spi_port_pkg::PTR_W-1:0] rd_addr,
	output logic [spi_port_pkg::WORD_W-1:0] rd_data
);
	logic [spi_port_pkg::WORD_W-1:0] mem_ff [spi_port_pkg::DEPTH];
	logic [spi_port_pkg::WORD_W-1:0] rd_data_ff;
	logic [spi_port_pkg::WORD_W-1:0] nxt_rd_data;

	// Forwarding keeps the head word valid in the cycle a word lands in an empty store
	always_comb begin
		nxt_rd_data = mem_ff[rd_addr];
		if (wr_en && (wr_addr == rd_addr)) begin
			nxt_rd_data = wr_data;
		end
	end

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem_ff[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_data_ff <= spi_port_pkg::WORD_ZERO;
		end else begin
			rd_data_ff <= nxt_rd_data;
		end
	end

	assign rd_data = rd_data_ff;
endmodule : word_store

// ==== bench/spi_port_checker.sv ====
`timescale 1ns/10ps
module spi_port_checker (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic port_enable,
	input wire logic framed_enable,
	input wire logic clock_output_off,
	input wire logic data_output_off,
	input wire logic idle_polarity_select,
	input wire logic buffer_multi,
	input wire logic overrun_clear,
	input wire logic tx_wr,
	input wire logic tx_buffer_full,
	input wire logic rx_buffer_full,
	input wire logic receive_overrun,
	input wire logic transfer_event_flag,
	input wire logic [spi_port_pkg::CNT_W-1:0] pending_count,
	input wire logic last_from_cpu,
	input wire logic sck_out,
	input wire logic sck_oe,
	input wire logic sdo_oe,
	input wire logic fsync_oe
);
	// ****************************************************************
	// Port rules
	// ****************************************************************
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	idle_clock_a: assert property (
		!port_enable [*2] |-> sck_out == idle_polarity_select) else $error("clock left idle");
	sdo_release_a: assert property (
		data_output_off [*2] |-> !sdo_oe) else $error("sdo driven while off");
	sck_release_a: assert property (
		clock_output_off [*2] |-> !sck_oe) else $error("sck driven while off");
	frame_off_a: assert property (
		!framed_enable [*2] |-> !fsync_oe) else $error("frame pin driven unframed");
	full_level_a: assert property (
		tx_buffer_full |-> pending_count == (buffer_multi ? spi_port_pkg::MULTI_LIMIT :
		spi_port_pkg::SINGLE_LIMIT)) else $error("full flag and count disagree");
	push_count_a: assert property (
		tx_wr && !tx_buffer_full && !port_enable |=> pending_count == $past(pending_count) + 3'h1)
		else $error("push not counted");
	cpu_source_a: assert property (
		tx_wr && !tx_buffer_full && !port_enable |=> last_from_cpu) else $error("source not cpu");
	rx_event_a: assert property (
		$rose(rx_buffer_full) |-> ##[0:2] transfer_event_flag) else $error("no event on receive");
	overrun_event_a: assert property (
		$rose(receive_overrun) |-> ##[0:2] transfer_event_flag) else $error("no event on overrun");
	overrun_hold_a: assert property (
		receive_overrun && !overrun_clear |=> receive_overrun) else $error("overrun lost");
	overrun_cause_a: assert property (
		$rose(receive_overrun) |-> rx_buffer_full) else $error("overrun with room");
	cover property (tx_buffer_full && buffer_multi);
	cover property ($rose(receive_overrun));
	cover property ($rose(rx_buffer_full));
	cover property (fsync_oe && framed_enable);
endmodule : spi_port_checker

bind spi_port_fifo_frame spi_port_checker u_spi_port_checker (.*);

// ==== bench/serial_peer.sv ====
`timescale 1ns/10ps
module serial_peer (
	input wire logic sck,
	input wire logic sdo,
	input wire logic load,
	input wire logic [15:0] load_word,
	output logic sdi,
	output logic [15:0] got_word
);
	logic [15:0] out_sr;
	initial sdi = 1'b0;
	initial got_word = 16'h0000;
	// Shift on the leading edge; a load flips the line so no stale bit lingers
	always @(posedge sck or posedge load) begin
		if (load) begin
			out_sr <= load_word;
			sdi <= ~sdi;
		end else begin
			sdi <= out_sr[15];
			out_sr <= {out_sr[14:0], 1'b0};
		end
	end
	always @(negedge sck) begin
		got_word <= {got_word[14:0], sdo};
	end
endmodule : serial_peer

// ==== bench/tb.sv ====
`timescale 1ns/10ps
module tb;
	typedef struct {logic wide; logic [15:0] tx; logic [15:0] peer; logic [15:0] rx;} row_t;
	logic clk, rst_b, port_enable, controller_select, wide_word_select, framed_enable;
	logic fsync_active_high, fsync_with_first_bit, clock_output_off, data_output_off;
	logic idle_polarity_select, clock_edge_select, sample_phase, select_input_enable;
	logic buffer_multi, overrun_clear, event_clear, tx_wr, rx_rd, sck_in, sdi_in, sel_b_in;
	logic fsync_in, tx_buffer_full, rx_buffer_full, receive_overrun, transfer_event_flag;
	logic last_from_cpu, sck_out, sck_oe, sdo_out, sdo_oe, fsync_out, fsync_oe, peer_load;
	logic [1:0] primary_prescale;
	logic [2:0] secondary_prescale, pending_count;
	logic [15:0] tx_data, rx_data, peer_word, got_word;
	int bad_count = 0;
	int checks_done = 0;
	logic pulse_seen = 1'b0;
	row_t rows [4] = '{'{1'b1, 16'ha55a, 16'h3c96, 16'h3c96}, '{1'b0, 16'hff81, 16'h6e00, 16'h006e},
		'{1'b1, 16'h8001, 16'hfffe, 16'hfffe}, '{1'b0, 16'h007f, 16'h8000, 16'h0080}};

	spi_port_fifo_frame u_spi_port_fifo_frame (.*);
	serial_peer u_serial_peer (.sck(sck_out), .sdo(sdo_out), .load(peer_load),
		.load_word(peer_word), .sdi(sdi_in), .got_word(got_word));
	assign sck_in = sck_out;
	// Latch any driven active-low frame pulse so a short one is not missed between checks
	always @(negedge clk) begin
		if (fsync_oe === 1'b1 && fsync_out === 1'b0) pulse_seen <= 1'b1;
	end

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ****************************************************************
	// Helpers
	// ****************************************************************
	task automatic cmp_bit(input logic got, input logic exp, input string what);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: %s is %b, expected %b", $time, what, got, exp);
		end
	endtask : cmp_bit
	task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: %s is %h, expected %h", $time, what, got, exp);
		end
	endtask : cmp_word
	task automatic push(input logic [15:0] w);
		@(posedge clk) tx_wr <= 1'b1;
		tx_data <= w;
		@(posedge clk) tx_wr <= 1'b0;
	endtask : push
	// Bounded so a lost event shows as a mismatch rather than a hang
	task automatic wait_flag;
		for (int i = 0; i < 3000; i++) begin
			@(negedge clk);
			if (transfer_event_flag === 1'b1) break;
		end
	endtask : wait_flag
	task automatic clear_flag;
		@(posedge clk) event_clear <= 1'b1;
		@(posedge clk) event_clear <= 1'b0;
	endtask : clear_flag
	task automatic pop;
		@(posedge clk) rx_rd <= 1'b1;
		@(posedge clk) rx_rd <= 1'b0;
	endtask : pop
	task automatic end_of_test;
		$display("checks %0d, mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test

	initial begin
		#100000;
		bad_count++;
		end_of_test();
	end

	// ****************************************************************
	// Sequence
	// ****************************************************************
	initial begin
		{port_enable, wide_word_select, framed_enable, fsync_active_high, fsync_with_first_bit} = '0;
		{clock_output_off, data_output_off, idle_polarity_select, clock_edge_select} = '0;
		{select_input_enable, buffer_multi, overrun_clear, event_clear, tx_wr, rx_rd} = '0;
		{fsync_in, peer_load, tx_data, peer_word} = '0;
		{controller_select, sample_phase, sel_b_in} = 3'h7;
		primary_prescale = 2'h2;
		secondary_prescale = 3'h6;
		rst_b = 1'b0;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		@(negedge clk);
		cmp_word({13'h0000, pending_count}, 16'h0000, "pending");
		cmp_bit(rx_buffer_full, 1'b0, "rx full");
		@(posedge clk) overrun_clear <= 1'b1;
		@(posedge clk) overrun_clear <= 1'b0;
		@(posedge clk) port_enable <= 1'b1;
		repeat (4) @(negedge clk);
		cmp_bit(sck_oe, 1'b1, "master sck enable");
		cmp_bit(sdo_oe, 1'b1, "sdo enable");
		$display("reset test done");
		foreach (rows[k]) begin
			@(posedge clk) wide_word_select <= rows[k].wide;
			peer_word <= rows[k].peer;
			peer_load <= 1'b1;
			@(posedge clk) peer_load <= 1'b0;
			push(rows[k].tx);
			wait_flag();
			cmp_bit(transfer_event_flag, 1'b1, "event");
			cmp_word(rx_data, rows[k].rx, "rx word");
			cmp_word(rows[k].wide ? got_word : {8'h00, got_word[7:0]},
				rows[k].wide ? rows[k].tx : {8'h00, rows[k].tx[7:0]}, "sent word");
			cmp_bit(last_from_cpu, 1'b0, "source rx");
			clear_flag();
			pop();
			@(negedge clk);
			cmp_bit(rx_buffer_full, 1'b0, "rx empty");
			$display("row %0d done", k);
		end
		// Fill while idle: one push past the limit must be dropped
		@(posedge clk) port_enable <= 1'b0;
		buffer_multi <= 1'b1;
		tx_wr <= 1'b1;
		repeat (5) @(posedge clk);
		tx_wr <= 1'b0;
		@(negedge clk);
		cmp_word({13'h0000, pending_count}, 16'h0004, "pending full");
		cmp_bit(tx_buffer_full, 1'b1, "tx full");
		cmp_bit(last_from_cpu, 1'b1, "source cpu");
		cmp_bit(sck_out, 1'b0, "idle clock");
		@(posedge clk) port_enable <= 1'b1;
		repeat (4) begin
			wait_flag();
			clear_flag();
		end
		@(negedge clk);
		cmp_word({13'h0000, pending_count}, 16'h0000, "pending drained");
		cmp_bit(receive_overrun, 1'b0, "no overrun");
		repeat (4) pop();
		@(negedge clk);
		cmp_bit(rx_buffer_full, 1'b0, "rx drained");
		$display("buffer test done");
		@(posedge clk) buffer_multi <= 1'b0;
		repeat (3) begin
			push(16'h5aa5);
			wait_flag();
			cmp_bit(transfer_event_flag, 1'b1, "event on word");
			clear_flag();
		end
		cmp_bit(receive_overrun, 1'b1, "overrun");
		@(posedge clk) overrun_clear <= 1'b1;
		@(posedge clk) overrun_clear <= 1'b0;
		pop();
		@(negedge clk);
		cmp_bit(receive_overrun, 1'b0, "overrun cleared");
		$display("overrun test done");
		// Framed master word: active-low pulse one bit period ahead of data
		@(posedge clk) framed_enable <= 1'b1;
		push(16'h00c3);
		wait_flag();
		cmp_bit(fsync_oe, 1'b1, "frame pin driven");
		cmp_bit(pulse_seen, 1'b1, "frame pulse");
		cmp_bit(fsync_out, 1'b1, "frame idle level");
		cmp_word({8'h00, got_word[7:0]}, 16'h00c3, "framed word");
		clear_flag();
		pop();
		@(posedge clk) framed_enable <= 1'b0;
		$display("frame test done");
		@(posedge clk) port_enable <= 1'b0;
		idle_polarity_select <= 1'b1;
		{data_output_off, clock_output_off, fsync_active_high, fsync_with_first_bit} <= 4'hf;
		repeat (4) @(negedge clk);
		cmp_bit(sck_out, 1'b1, "idle high clock");
		cmp_bit(sdo_oe, 1'b0, "sdo released");
		cmp_bit(sck_oe, 1'b0, "sck released");
		cmp_bit(fsync_oe, 1'b0, "frame released");
		$display("output test done");
		end_of_test();
	end
endmodule : tb
